// ---- snspfe_pkg.sv ----
// Constants, opcodes and register layout shared by the serial NAND pin front end.
package snspfe_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [3:0] SNSPFE_OFS_CTRL   = 4'h0;
  localparam logic [3:0] SNSPFE_OFS_STATUS = 4'h4;
  localparam logic [3:0] SNSPFE_OFS_RXDATA = 4'h8;
  localparam logic [3:0] SNSPFE_OFS_TXDATA = 4'hC;

  // Control register fields.
  localparam int SNSPFE_CTRL_HPE    = 0;
  localparam int SNSPFE_CTRL_BP_LO  = 1;
  localparam int SNSPFE_CTRL_SRP_LO = 5;
  localparam int SNSPFE_CTRL_HDR_LO = 8;
  localparam logic [9:0] SNSPFE_CTRL_RESET = 10'h31E;

  // Status register fields.
  localparam int SNSPFE_ST_SELECTED = 0;
  localparam int SNSPFE_ST_PAUSED   = 1;
  localparam int SNSPFE_ST_QUAD     = 2;
  localparam int SNSPFE_ST_ARMED    = 3;
  localparam int SNSPFE_ST_RXVALID  = 4;
  localparam int SNSPFE_ST_REFUSED  = 5;
  localparam int SNSPFE_ST_REGION   = 6;
  localparam int SNSPFE_ST_OPC_LO   = 8;
  localparam int SNSPFE_ST_PBLK_LO  = 16;

  // Array geometry used for region protection.
  localparam logic [10:0] SNSPFE_NUM_BLOCKS  = 11'h400;
  localparam logic [3:0]  SNSPFE_BP_ALL      = 4'hA;
  localparam int          SNSPFE_PAGE_SHIFT  = 6;

  // Instruction bytes that set data direction, lane usage or protection handling.
  localparam logic [7:0] SNSPFE_OPC_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] SNSPFE_OPC_DUAL_IO   = 8'hBB;
  localparam logic [7:0] SNSPFE_OPC_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] SNSPFE_OPC_QUAD_IO   = 8'hEB;
  localparam logic [7:0] SNSPFE_OPC_QUAD_LD   = 8'h32;
  localparam logic [7:0] SNSPFE_OPC_QUAD_RLD  = 8'h34;
  localparam logic [7:0] SNSPFE_OPC_READ      = 8'h03;
  localparam logic [7:0] SNSPFE_OPC_FAST_READ = 8'h0B;
  localparam logic [7:0] SNSPFE_OPC_RD_STAT   = 8'h0F;
  localparam logic [7:0] SNSPFE_OPC_RD_STAT2  = 8'h05;
  localparam logic [7:0] SNSPFE_OPC_WR_STAT   = 8'h1F;
  localparam logic [7:0] SNSPFE_OPC_WR_STAT2  = 8'h01;
  localparam logic [7:0] SNSPFE_OPC_WR_EN     = 8'h06;
  localparam logic [7:0] SNSPFE_OPC_LOAD      = 8'h02;
  localparam logic [7:0] SNSPFE_OPC_RLOAD     = 8'h84;
  localparam logic [7:0] SNSPFE_OPC_PROG_EXE  = 8'h10;
  localparam logic [7:0] SNSPFE_OPC_ERASE     = 8'hD8;

  // Lane width codes: width in lines is 1 << code.
  typedef enum logic [1:0] {SNSPFE_W1 = 2'h0, SNSPFE_W2 = 2'h1, SNSPFE_W4 = 2'h2} snspfe_lanes_t;

endpackage

// ---- snspfe_top.sv ----
// Pin front end of a serial NAND flash: chip select, lane control, protection, pause and AHB-Lite registers.
//
// Contract
// - Chip select high deselects and floats every output-capable data line.
// - Instructions are ignored after power-up until chip select has fallen once.
// - Single-line commands, address and write data are sampled on rising clock edges.
// - Single-line read data leaves on serial_out, changing on falling clock edges.
// - Dual and quad lines take input on rising edges, drive on falling edges.
// - Single and dual use lines 0 and 1; quad uses all four lines.
// - Protect enable clear: pin guards only the protection register, doubles as line 2.
// - Protect enable set and pin low: every write, program and erase refused.
// - Quad reads are disabled while hardware protect enable is set.
// - Pause low while selected floats serial_out and ignores serial_in and clock.
// - Releasing pause resumes the held instruction exactly where it stopped.
// - During quad read or load the pause pin is data line 3, no pause.
// - Clock modes 0 and 3 are both accepted at chip select edges.
// - Block and register protect bits with the pin protect two blocks to all; here a program or erase into the region only sets the region flag.
// - Pause starts at pause fall if clock low, else after next clock fall.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
module snspfe_top
  import snspfe_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        spi_clk,
  input  wire logic        chip_select_n,
  input  wire logic        data_line_0_in,
  output logic             data_line_0_out,
  output logic             data_line_0_oe,
  input  wire logic        data_line_1_in,
  output logic             data_line_1_out,
  output logic             data_line_1_oe,
  input  wire logic        data_line_2_in,
  output logic             data_line_2_out,
  output logic             data_line_2_oe,
  input  wire logic        data_line_3_in,
  output logic             data_line_3_out,
  output logic             data_line_3_oe
);

  typedef enum logic [2:0] {SNSPFE_OPC, SNSPFE_HDR, SNSPFE_DIN, SNSPFE_DOUT, SNSPFE_IGNORE} snspfe_state_t;

  function automatic logic opc_is_quad(input logic [7:0] opc);
    opc_is_quad = (opc == SNSPFE_OPC_QUAD_OUT) || (opc == SNSPFE_OPC_QUAD_IO) ||
                  (opc == SNSPFE_OPC_QUAD_LD) || (opc == SNSPFE_OPC_QUAD_RLD);
  endfunction

  function automatic logic opc_is_read(input logic [7:0] opc);
    opc_is_read = (opc == SNSPFE_OPC_READ) || (opc == SNSPFE_OPC_FAST_READ) ||
                  (opc == SNSPFE_OPC_DUAL_OUT) || (opc == SNSPFE_OPC_DUAL_IO) ||
                  (opc == SNSPFE_OPC_QUAD_OUT) || (opc == SNSPFE_OPC_QUAD_IO) ||
                  (opc == SNSPFE_OPC_RD_STAT) || (opc == SNSPFE_OPC_RD_STAT2);
  endfunction

  function automatic logic opc_is_wrstat(input logic [7:0] opc);
    opc_is_wrstat = (opc == SNSPFE_OPC_WR_STAT) || (opc == SNSPFE_OPC_WR_STAT2);
  endfunction

  function automatic logic opc_is_write(input logic [7:0] opc);
    opc_is_write = opc_is_wrstat(opc) || (opc == SNSPFE_OPC_WR_EN) || (opc == SNSPFE_OPC_LOAD) ||
                   (opc == SNSPFE_OPC_RLOAD) || (opc == SNSPFE_OPC_QUAD_LD) ||
                   (opc == SNSPFE_OPC_QUAD_RLD) || (opc == SNSPFE_OPC_PROG_EXE) ||
                   (opc == SNSPFE_OPC_ERASE);
  endfunction

  function automatic snspfe_lanes_t opc_data_lanes(input logic [7:0] opc);
    if (opc_is_quad(opc))
      opc_data_lanes = SNSPFE_W4;
    else if ((opc == SNSPFE_OPC_DUAL_OUT) || (opc == SNSPFE_OPC_DUAL_IO))
      opc_data_lanes = SNSPFE_W2;
    else
      opc_data_lanes = SNSPFE_W1;
  endfunction

  // ---------------- Host clock domain: AHB-Lite slave and registers ----------------
  logic [9:0]  ctrl_q, ctrl_d;
  logic [7:0]  tx_byte_q, tx_byte_d;
  logic        tx_tog_q, tx_tog_d;
  logic        rx_valid_q, rx_valid_d;
  logic        refused_q, refused_d;
  logic        region_q, region_d;
  logic [7:0]  last_opc_q, last_opc_d;
  logic [7:0]  rd_byte_q, rd_byte_d;
  logic [15:0] page_q, page_d;
  logic        wr_pend_q, wr_pend_d;
  logic [3:0]  wr_ofs_q, wr_ofs_d;
  logic [31:0] hrdata_d;
  logic [1:0]  wp_sync_q, cs_sync_q;
  logic [2:0]  rx_tog_sync_q;
  logic [1:0]  paused_sync_q, quad_sync_q;
  logic [10:0] prot_blocks;
  logic        addr_ok;
  logic        rx_event;

  // Link-side signals that cross into the host domain.
  logic        rx_tog_q;
  logic [7:0]  rx_byte_q;
  logic [1:0]  rx_idx_q;
  logic        rx_refused_q;
  logic        quad_q;
  logic        hold_q;
  logic        armed_q;

  assign addr_ok  = hsel && htrans[1] && hready;
  assign rx_event = rx_tog_sync_q[2] != rx_tog_sync_q[1];

  // Smallest region is two blocks, doubling per step, whole array from code SNSPFE_BP_ALL up.
  always_comb
  begin
    if (ctrl_q[SNSPFE_CTRL_BP_LO +: 4] == 4'h0)
      prot_blocks = 11'h000;
    else if (ctrl_q[SNSPFE_CTRL_BP_LO +: 4] >= SNSPFE_BP_ALL)
      prot_blocks = SNSPFE_NUM_BLOCKS;
    else
      prot_blocks = 11'(11'h001 << ctrl_q[SNSPFE_CTRL_BP_LO +: 4]);
  end

  always_comb
  begin
    ctrl_d     = ctrl_q;
    tx_byte_d  = tx_byte_q;
    tx_tog_d   = tx_tog_q;
    rx_valid_d = rx_valid_q;
    refused_d  = refused_q;
    region_d   = region_q;
    last_opc_d = last_opc_q;
    rd_byte_d  = rd_byte_q;
    page_d     = page_q;
    wr_pend_d  = addr_ok && hwrite;
    wr_ofs_d   = haddr[3:0];
    hrdata_d   = hrdata;
    if (addr_ok && !hwrite)
    begin
      case (haddr[3:0])
        SNSPFE_OFS_CTRL:   hrdata_d = {22'h000000, ctrl_q};
        SNSPFE_OFS_STATUS: hrdata_d = {5'h00, prot_blocks, last_opc_q, 1'b0, region_q, refused_q, rx_valid_q,
                                       armed_q, quad_sync_q[1], paused_sync_q[1], cs_sync_q[1] == 1'b0};
        SNSPFE_OFS_RXDATA: hrdata_d = {24'h000000, rd_byte_q};
        SNSPFE_OFS_TXDATA: hrdata_d = {24'h000000, tx_byte_q};
        default:           hrdata_d = 32'h00000000;
      endcase
      if (haddr[3:0] == SNSPFE_OFS_RXDATA)
        rx_valid_d = 1'b0;
    end
    if (wr_pend_q)
    begin
      case (wr_ofs_q)
        SNSPFE_OFS_CTRL:   ctrl_d = hwdata[9:0];
        SNSPFE_OFS_STATUS:
        begin
          if (hwdata[SNSPFE_ST_REFUSED])
            refused_d = 1'b0;
          if (hwdata[SNSPFE_ST_REGION])
            region_d = 1'b0;
        end
        SNSPFE_OFS_TXDATA:
        begin
          tx_byte_d = hwdata[7:0];
          tx_tog_d  = !tx_tog_q;
        end
        default: ;
      endcase
    end
    // Hardware events are applied last so that a set in the clearing cycle wins.
    if (rx_event)
    begin
      rx_valid_d = 1'b1;
      rd_byte_d  = rx_byte_q;
      if (rx_refused_q)
        refused_d = 1'b1;
      if (rx_idx_q == 2'h0)
        last_opc_d = rx_byte_q;
      if (rx_idx_q == 2'h2)
        page_d[15:8] = rx_byte_q;
      if ((rx_idx_q == 2'h3) && ((last_opc_q == SNSPFE_OPC_PROG_EXE) || (last_opc_q == SNSPFE_OPC_ERASE)))
      begin
        page_d[7:0] = rx_byte_q;
        if ({1'b0, page_q[15:SNSPFE_PAGE_SHIFT]} >= (SNSPFE_NUM_BLOCKS - prot_blocks)
            && (prot_blocks != 11'h000) && (ctrl_q[SNSPFE_CTRL_HPE] ? !wp_sync_q[1] : 1'b1))
          region_d = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q        <= SNSPFE_CTRL_RESET;
      tx_byte_q     <= 8'h00;
      tx_tog_q      <= 1'b0;
      rx_valid_q    <= 1'b0;
      refused_q     <= 1'b0;
      region_q      <= 1'b0;
      last_opc_q    <= 8'h00;
      rd_byte_q     <= 8'h00;
      page_q        <= 16'h0000;
      wr_pend_q     <= 1'b0;
      wr_ofs_q      <= 4'h0;
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b0;
      hresp         <= 1'b0;
      wp_sync_q     <= 2'h3;
      cs_sync_q     <= 2'h3;
      rx_tog_sync_q <= 3'h0;
      paused_sync_q <= 2'h0;
      quad_sync_q   <= 2'h0;
    end
    else
    begin
      ctrl_q        <= ctrl_d;
      tx_byte_q     <= tx_byte_d;
      tx_tog_q      <= tx_tog_d;
      rx_valid_q    <= rx_valid_d;
      refused_q     <= refused_d;
      region_q      <= region_d;
      last_opc_q    <= last_opc_d;
      rd_byte_q     <= rd_byte_d;
      page_q        <= page_d;
      wr_pend_q     <= wr_pend_d;
      wr_ofs_q      <= wr_ofs_d;
      hrdata        <= hrdata_d;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      wp_sync_q     <= {wp_sync_q[0], data_line_2_in};
      cs_sync_q     <= {cs_sync_q[0], chip_select_n};
      rx_tog_sync_q <= {rx_tog_sync_q[1:0], rx_tog_q};
      paused_sync_q <= {paused_sync_q[0], hold_q};
      quad_sync_q   <= {quad_sync_q[0], quad_q};
    end
  end

  // ---------------- Link clock domain ----------------
  // Configuration is quasi-static; it settles within the opcode byte of a frame.
  logic [3:0] cfg_meta_q, cfg_q;
  logic [3:0] cfg_in;
  logic       cfg_hpe, cfg_hw_lock, cfg_sw_lock;
  logic [1:0] cfg_hdr;

  assign cfg_in = {ctrl_q[SNSPFE_CTRL_HPE] && !wp_sync_q[1],
                   !ctrl_q[SNSPFE_CTRL_HPE] && !wp_sync_q[1] && (ctrl_q[SNSPFE_CTRL_SRP_LO +: 2] != 2'h0),
                   ctrl_q[SNSPFE_CTRL_HPE],
                   1'b0};
  assign cfg_hw_lock = cfg_q[3];
  assign cfg_sw_lock = cfg_q[2];
  assign cfg_hpe     = cfg_q[1];
  assign cfg_hdr     = ctrl_q[SNSPFE_CTRL_HDR_LO +: 2];

  // The armed flag only sets on a real select edge, so a select held low from power-up is ignored.
  always_ff @(negedge chip_select_n or negedge hresetn)
  begin
    if (!hresetn)
      armed_q <= 1'b0;
    else
      armed_q <= 1'b1;
  end

  snspfe_state_t state_q, state_d;
  snspfe_lanes_t lanes_q, lanes_d;
  logic [7:0]    shift_q, shift_d;
  // The opcode is kept while the header streams through the shifter.
  logic [7:0]    opc_hold_q;
  logic [2:0]    bit_cnt_q, bit_cnt_d;
  logic [1:0]    hdr_cnt_q, hdr_cnt_d;
  logic [1:0]    idx_q, idx_d;
  logic          quad_d;
  logic          paused_rise;
  logic          byte_done;
  logic [3:0]    bits_in;
  logic [7:0]    shifted;
  logic [7:0]    opc_now;
  logic          refuse_now;
  logic          rx_fire;

  // Pause is a level on the pin at a rising edge; in quad operation the pin is line 3.
  assign paused_rise = !quad_q && !data_line_3_in;

  always_comb
  begin
    case (lanes_q)
      SNSPFE_W4: bits_in = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
      SNSPFE_W2: bits_in = {2'h0, data_line_1_in, data_line_0_in};
      default:   bits_in = {3'h0, data_line_0_in};
    endcase
    case (lanes_q)
      SNSPFE_W4: shifted = {shift_q[3:0], bits_in};
      SNSPFE_W2: shifted = {shift_q[5:0], bits_in[1:0]};
      default:   shifted = {shift_q[6:0], bits_in[0]};
    endcase
    byte_done  = (4'(bit_cnt_q) + (4'h1 << lanes_q)) == 4'h8;
    opc_now    = shifted;
    refuse_now = !armed_q
                 || (cfg_hw_lock && opc_is_write(opc_now))
                 || (cfg_sw_lock && opc_is_wrstat(opc_now))
                 || (cfg_hpe && opc_is_quad(opc_now));
  end

  always_comb
  begin
    state_d   = state_q;
    lanes_d   = lanes_q;
    shift_d   = shift_q;
    bit_cnt_d = bit_cnt_q;
    hdr_cnt_d = hdr_cnt_q;
    idx_d     = idx_q;
    quad_d    = quad_q;
    rx_fire   = 1'b0;
    // While paused every frame register keeps its value, so the instruction resumes intact.
    if (!paused_rise && (state_q != SNSPFE_IGNORE))
    begin
      shift_d   = shifted;
      bit_cnt_d = 3'(4'(bit_cnt_q) + (4'h1 << lanes_q));
      if (byte_done && (state_q != SNSPFE_DOUT))
      begin
        bit_cnt_d = 3'h0;
        rx_fire   = 1'b1;
        if (idx_q != 2'h3)
          idx_d = idx_q + 2'h1;
        case (state_q)
          SNSPFE_OPC:
          begin
            hdr_cnt_d = cfg_hdr;
            quad_d    = opc_is_quad(opc_now) && !refuse_now;
            if (refuse_now)
              state_d = SNSPFE_IGNORE;
            else if (cfg_hdr != 2'h0)
              state_d = SNSPFE_HDR;
            else
              state_d = opc_is_read(opc_now) ? SNSPFE_DOUT : SNSPFE_DIN;
            if ((opc_now == SNSPFE_OPC_DUAL_IO) || (opc_now == SNSPFE_OPC_QUAD_IO))
              lanes_d = opc_data_lanes(opc_now);
            else if (!opc_is_read(opc_now) || (cfg_hdr == 2'h0))
              lanes_d = opc_data_lanes(opc_now);
          end
          SNSPFE_HDR:
          begin
            hdr_cnt_d = hdr_cnt_q - 2'h1;
            if (hdr_cnt_q == 2'h1)
            begin
              state_d = opc_is_read(opc_hold_q) ? SNSPFE_DOUT : SNSPFE_DIN;
              lanes_d = opc_data_lanes(opc_hold_q);
            end
          end
          default: ;
        endcase
      end
      else if (state_q == SNSPFE_DOUT)
        bit_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge spi_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      state_q    <= SNSPFE_OPC;
      lanes_q    <= SNSPFE_W1;
      shift_q    <= 8'h00;
      bit_cnt_q  <= 3'h0;
      hdr_cnt_q  <= 2'h0;
      idx_q      <= 2'h0;
      quad_q     <= 1'b0;
      opc_hold_q <= 8'h00;
    end
    else
    begin
      state_q    <= state_d;
      lanes_q    <= lanes_d;
      shift_q    <= shift_d;
      bit_cnt_q  <= bit_cnt_d;
      hdr_cnt_q  <= hdr_cnt_d;
      idx_q      <= idx_d;
      quad_q     <= quad_d;
      opc_hold_q <= (state_q == SNSPFE_OPC) && rx_fire ? opc_now : opc_hold_q;
    end
  end

  // Event flops survive chip select so the toggle never gives a false edge.
  always_ff @(posedge spi_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_meta_q   <= 4'h0;
      cfg_q        <= 4'h0;
      rx_tog_q     <= 1'b0;
      rx_byte_q    <= 8'h00;
      rx_idx_q     <= 2'h0;
      rx_refused_q <= 1'b0;
    end
    else
    begin
      cfg_meta_q <= cfg_in;
      cfg_q      <= cfg_meta_q;
      if (rx_fire && !chip_select_n)
      begin
        rx_tog_q     <= !rx_tog_q;
        rx_byte_q    <= shifted;
        rx_idx_q     <= idx_q;
        rx_refused_q <= (state_q == SNSPFE_OPC) && refuse_now;
      end
    end
  end

  // Falling-edge side: pause capture, transmit handshake and pin drive.
  logic [1:0] tx_sync_q;
  logic       tx_seen_q;
  logic [7:0] tx_hold_q;
  logic [7:0] out_sh_q;
  logic [2:0] out_cnt_q;
  logic [3:0] drv_q;
  logic [3:0] oe_q;
  logic       pause_pin;

  always_ff @(negedge spi_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_sync_q <= 2'h0;
      tx_seen_q <= 1'b0;
      tx_hold_q <= 8'h00;
    end
    else
    begin
      tx_sync_q <= {tx_sync_q[0], tx_tog_q};
      if (tx_sync_q[1] != tx_seen_q)
      begin
        tx_seen_q <= tx_sync_q[1];
        tx_hold_q <= tx_byte_q;
      end
    end
  end

  always_ff @(negedge spi_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      hold_q    <= 1'b0;
      out_sh_q  <= 8'h00;
      out_cnt_q <= 3'h0;
      drv_q     <= 4'h0;
      oe_q      <= 4'h0;
    end
    else
    begin
      hold_q <= !quad_q && !data_line_3_in;
      if ((state_q == SNSPFE_DOUT) && (quad_q || data_line_3_in))
      begin
        oe_q      <= (lanes_q == SNSPFE_W4) ? 4'hF : (lanes_q == SNSPFE_W2) ? 4'h3 : 4'h2;
        out_sh_q  <= (out_cnt_q == 3'h0) ? 8'(tx_hold_q << (4'h1 << lanes_q)) : 8'(out_sh_q << (4'h1 << lanes_q));
        out_cnt_q <= 3'(4'(out_cnt_q) + (4'h1 << lanes_q));
        case (lanes_q)
          SNSPFE_W4: drv_q <= (out_cnt_q == 3'h0) ? tx_hold_q[7:4] : out_sh_q[7:4];
          SNSPFE_W2: drv_q <= {2'h0, (out_cnt_q == 3'h0) ? tx_hold_q[7:6] : out_sh_q[7:6]};
          default:   drv_q <= {2'h0, (out_cnt_q == 3'h0) ? tx_hold_q[7] : out_sh_q[7], 1'b0};
        endcase
      end
    end
  end

  // Pause floats the lines at once when the clock is low, else from the falling edge.
  assign pause_pin = !quad_q && (spi_clk ? hold_q : !data_line_3_in);

  assign data_line_0_out = drv_q[0];
  assign data_line_1_out = drv_q[1];
  assign data_line_2_out = drv_q[2];
  assign data_line_3_out = drv_q[3];
  assign data_line_0_oe  = oe_q[0] && !chip_select_n && !pause_pin;
  assign data_line_1_oe  = oe_q[1] && !chip_select_n && !pause_pin;
  assign data_line_2_oe  = oe_q[2] && !chip_select_n && !pause_pin;
  assign data_line_3_oe  = oe_q[3] && !chip_select_n && !pause_pin;

  logic unused_bits;
  assign unused_bits = ^{haddr[31:4], hsize, cfg_q[0], paused_rise, hrdata_d[31:27]};

endmodule

// ---- snspfe_top_props.sv ----
// Concurrent checks on the pin front end ports.
module snspfe_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic data_line_1_out,
  input wire logic data_line_3_in,
  input wire logic data_line_0_oe,
  input wire logic data_line_1_oe,
  input wire logic data_line_2_oe,
  input wire logic data_line_3_oe
);
  logic rise_q;
  // The output seen at a rising edge must survive to the falling edge.
  always_ff @(posedge spi_clk)
  begin
    rise_q <= data_line_1_out;
  end
  sequence s_paused;
    !chip_select_n && !data_line_3_in && !data_line_3_oe;
  endsequence
  property p_desel_float;
    @(posedge hclk) disable iff (!hresetn)
    chip_select_n |-> !(data_line_0_oe || data_line_1_oe || data_line_2_oe || data_line_3_oe);
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("line driven while deselected");
  property p_cs_abort;
    @(posedge hclk) disable iff (!hresetn) $rose(chip_select_n) |-> !data_line_1_oe ##1 !data_line_1_oe;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("output kept after select release");
  property p_okay;
    @(posedge hclk) disable iff (!hresetn) hresp == 1'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_ready;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("bus slave stalled");
  property p_quad_lanes;
    @(posedge hclk) disable iff (!hresetn)
    (data_line_2_oe || data_line_3_oe) |-> data_line_0_oe && data_line_1_oe && data_line_2_oe && data_line_3_oe;
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) else $error("partial quad drive");
  property p_dual_pair;
    @(posedge hclk) disable iff (!hresetn) data_line_0_oe |-> data_line_1_oe;
  endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("line 0 driven without line 1");
  property p_pause_float;
    @(posedge hclk) disable iff (!hresetn) s_paused [*3] |-> !data_line_1_oe;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("output driven while paused");
  property p_out_falling;
    @(negedge spi_clk) disable iff (!hresetn || chip_select_n) data_line_1_oe |-> data_line_1_out == rise_q;
  endproperty
  a_out_falling: assert property (p_out_falling) else $error("output moved on rising edge");
endmodule

bind snspfe_top snspfe_chk i_snspfe_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .spi_clk(spi_clk),
  .chip_select_n(chip_select_n), .data_line_1_out(data_line_1_out), .data_line_3_in(data_line_3_in),
  .data_line_0_oe(data_line_0_oe), .data_line_1_oe(data_line_1_oe), .data_line_2_oe(data_line_2_oe),
  .data_line_3_oe(data_line_3_oe)
);

// ---- snspfe_host.sv ----
// Behavioural SPI host facing the link side of the pin front end.
module snspfe_host (
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      serial_in,
  output logic      write_protect_n,
  output logic      pause_n,
  input  wire logic data_line_1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol;
  initial
  begin
    cpol = 1'h0;
    spi_clk = 1'h0;
    chip_select_n = 1'h0;
    serial_in = 1'h0;
    write_protect_n = 1'h1;
    pause_n = 1'h1;
  end
  // The clock stands at its idle level of the mode at both select edges.
  task sel(input logic lvl);
    spi_clk = cpol;
    #33 chip_select_n = lvl;
    #20 if (!lvl) spi_clk = 1'h0;
  endtask
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = tx[i];
      #40 spi_clk = 1'h1;
      #20 rx[i] = data_line_1;
      #20 spi_clk = 1'h0;
    end
  endtask
endmodule

// ---- snspfe_top_tb.sv ----
// Self-checking bench for the serial NAND pin front end.
module snspfe_top_tb
  import snspfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, spi_clk, cs_n, s_in, wp_n, pause_n, l1;
  logic        o0, o1, o2, o3, e0, e1, e2, e3;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  rx;
  int          error_cnt, samples_checked;
  logic [9:0]  t_ctl [8] = '{10'h01F, 10'h01E, 10'h01F, 10'h01F, 10'h03E, 10'h01E, 10'h01E, 10'h01F};
  logic [7:0]  t_opc [8] = '{8'h6B, 8'h6B, 8'h02, 8'h02, 8'h1F, 8'h1F, 8'h3B, 8'hEB};
  logic [7:0]  t_wp = 8'hC9;
  logic [7:0]  t_ref = 8'h95;
  // A released line shows the link clock, so a floating read never looks like data.
  assign l1 = e1 ? o1 : spi_clk;
  initial
  begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  snspfe_top i_snspfe_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .spi_clk(spi_clk), .chip_select_n(cs_n), .data_line_0_in(e0 ? o0 : s_in), .data_line_0_out(o0),
    .data_line_0_oe(e0), .data_line_1_in(l1), .data_line_1_out(o1), .data_line_1_oe(e1),
    .data_line_2_in(e2 ? o2 : wp_n), .data_line_2_out(o2), .data_line_2_oe(e2),
    .data_line_3_in(e3 ? o3 : pause_n), .data_line_3_out(o3), .data_line_3_oe(e3)
  );
  snspfe_host i_snspfe_host (
    .spi_clk(spi_clk), .chip_select_n(cs_n), .serial_in(s_in), .write_protect_n(wp_n), .pause_n(pause_n),
    .data_line_1(l1)
  );
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task ahb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {28'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task frame(input logic [7:0] opc);
    i_snspfe_host.sel(1'h1);
    i_snspfe_host.sel(1'h0);
    i_snspfe_host.xfer(opc, rx);
  endtask
  initial
  begin
    hresetn = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    // A select pulse inside reset clears the frame logic but must not arm the device.
    #5 i_snspfe_host.chip_select_n = 1'h1;
    #5 i_snspfe_host.chip_select_n = 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, SNSPFE_OFS_CTRL, 32'h0);
    chk(rd, {22'h0, SNSPFE_CTRL_RESET});
    i_snspfe_host.xfer(SNSPFE_OPC_READ, rx);
    i_snspfe_host.xfer(8'h00, rx);
    chk({24'h0, rx}, 32'hFF);
    ahb(1'h1, SNSPFE_OFS_TXDATA, 32'hA5);
    ahb(1'h1, SNSPFE_OFS_CTRL, 32'h01E);
    for (int m = 0; m < 2; m++)
    begin
      i_snspfe_host.cpol = m[0];
      frame(SNSPFE_OPC_READ);
      i_snspfe_host.xfer(8'h00, rx);
      chk({24'h0, rx}, 32'hA5);
    end
    ahb(1'h0, SNSPFE_OFS_STATUS, 32'h0);
    chk({24'h0, rd[SNSPFE_ST_OPC_LO +: 8]}, {24'h0, SNSPFE_OPC_READ});
    chk({21'h0, rd[SNSPFE_ST_PBLK_LO +: 11]}, {21'h0, SNSPFE_NUM_BLOCKS});
    i_snspfe_host.cpol = 1'h0;
    frame(SNSPFE_OPC_READ);
    #10 i_snspfe_host.pause_n = 1'h0;
    i_snspfe_host.xfer(8'hFF, rx);
    chk({24'h0, rx}, 32'hFF);
    ahb(1'h0, SNSPFE_OFS_STATUS, 32'h0);
    chk({31'h0, rd[SNSPFE_ST_PAUSED]}, 32'h1);
    i_snspfe_host.pause_n = 1'h1;
    i_snspfe_host.xfer(8'h00, rx);
    chk({24'h0, rx}, 32'hA5);
    for (int k = 0; k < 8; k++)
    begin
      ahb(1'h1, SNSPFE_OFS_CTRL, {22'h0, t_ctl[k]});
      i_snspfe_host.write_protect_n = t_wp[k];
      frame(t_opc[k]);
      i_snspfe_host.xfer(8'h00, rx);
      i_snspfe_host.sel(1'h1);
      ahb(1'h0, SNSPFE_OFS_STATUS, 32'h0);
      chk({31'h0, rd[SNSPFE_ST_REFUSED]}, {31'h0, t_ref[k]});
      ahb(1'h1, SNSPFE_OFS_STATUS, 32'h20);
    end
    test_done();
  end
endmodule
